// file: src/kpmc_pkg.sv
// Package of constants and carrier types for the keypad mode controller.
package kpmc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] KPMC_OFS_CTRL = 12'h000;
  localparam logic [11:0] KPMC_OFS_STATUS = 12'h004;
  localparam logic [11:0] KPMC_OFS_RANGE = 12'h008;
  localparam logic [11:0] KPMC_OFS_SPAN = 12'h00C;
  localparam logic [11:0] KPMC_OFS_TRIM = 12'h010;
  localparam logic [11:0] KPMC_OFS_READING = 12'h014;
  localparam logic [11:0] KPMC_OFS_ALARM = 12'h018;
  localparam logic [11:0] KPMC_OFS_OUTPUT = 12'h01C;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int KPMC_CTRL_TRACE_BIT = 0;
  localparam int KPMC_CTRL_SENSOR_ZERO_BIT = 1;
  localparam logic [15:0] KPMC_RANGE_MIN_PPM = 16'h000A;
  localparam logic [15:0] KPMC_RANGE_MIN_PCT_PPM = 16'h0001;
  localparam logic [15:0] KPMC_RANGE_PPM_CEIL = 16'h03E8;
  localparam logic [15:0] KPMC_RANGE_MAX_PCT = 16'h0019;
  localparam logic [15:0] KPMC_RANGE_RESET = 16'h0064;
  localparam logic [15:0] KPMC_SPAN_RESET = 16'h03E8;
  localparam logic [15:0] KPMC_TRIM_LO_RESET = 16'h0333;
  localparam logic [15:0] KPMC_TRIM_HI_RESET = 16'h0FFF;
  localparam logic [15:0] KPMC_FAULT_LEVEL = 16'h02E1;
  localparam logic [15:0] KPMC_STEP = 16'h0001;
  localparam logic [7:0] KPMC_BOOT_COUNT = 8'h4A;
  localparam logic [15:0] KPMC_ALARM_FULL_TENTHS = 16'h012C;
  localparam logic [31:0] KPMC_ID_CODE = 32'h00C0FFEE; // Arbitrary value.
  localparam logic [31:0] KPMC_VERSION = 32'h00000104; // Arbitrary value.
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint KPMC_CLK_HZ = 40000000;
  localparam int KPMC_IDLE_MS = 3000;
  localparam int KPMC_HOLD_S = 10;
  localparam int KPMC_ALARM_MIN = 30;
  localparam int KPMC_DEBOUNCE_US = 10000;
  localparam int KPMC_BLINK_MS = 500;
  localparam int KPMC_BOOT_STEP_MS = 100;
  localparam int KPMC_IDLE_CYC = int'(KPMC_CLK_HZ / 1000 * KPMC_IDLE_MS);
  localparam int KPMC_HOLD_CYC = int'(KPMC_CLK_HZ * KPMC_HOLD_S);
  localparam int KPMC_TENTH_MIN_CYC = int'(KPMC_CLK_HZ * 6);
  localparam int KPMC_DEBOUNCE_CYC = int'(KPMC_CLK_HZ / 1000000 * KPMC_DEBOUNCE_US);
  localparam int KPMC_BLINK_CYC = int'(KPMC_CLK_HZ / 1000 * KPMC_BLINK_MS);
  localparam int KPMC_BOOT_STEP_CYC = int'(KPMC_CLK_HZ / 1000 * KPMC_BOOT_STEP_MS);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    KPMC_ST_POWERUP = 4'h0,
    KPMC_ST_ERASE = 4'h1,
    KPMC_ST_TRIM_LO = 4'h2,
    KPMC_ST_TRIM_HI = 4'h3,
    KPMC_ST_BOOT = 4'h4,
    KPMC_ST_RUN = 4'h5,
    KPMC_ST_ACCEPT1 = 4'h6,
    KPMC_ST_RANGE = 4'h7,
    KPMC_ST_SPAN = 4'h8,
    KPMC_ST_TIMER_SHOW = 4'h9
  } kpmc_state_e;
  typedef enum logic [2:0] {
    KPMC_MK_NONE = 3'h0,
    KPMC_MK_RANGE = 3'h1,
    KPMC_MK_SPAN = 3'h2,
    KPMC_MK_LOW = 3'h3,
    KPMC_MK_HIGH = 3'h4,
    KPMC_MK_BAR = 3'h5
  } kpmc_marker_e;
  typedef struct packed {
    logic up;
    logic down;
    logic accept;
    logic cancel;
  } kpmc_keys_s;
  typedef struct packed {
    logic [15:0] value;
    logic pct;
    logic blink;
    logic blank3;
    logic alt_warn;
    logic [2:0] marker;
  } kpmc_disp_s;
endpackage

// file: src/kpmc_top.sv
// Keypad mode controller: key handling, range, span, output trim and sensor watchdog.
`timescale 1ns/100ps
// Operation
// - Range may be set from the lowest trace range to the highest percent range.
// - The lowest trace range is allowed only with a trace sensor configured.
// - One accept press in run mode enters range mode with range marker.
// - In range mode each up or down press steps the bound by one.
// - No key press of any kind within the idle time returns range mode to run.
// - Raising past the ppm ceiling switches to percent with percent marker.
// - Range blinks while chosen; after idle it stops, stores and runs.
// - Two accept presses enter span mode, span blinks, span marker, arrows edit.
// - After idle in span mode, blink stops, marker clears, span stored, run.
// - Cancel in span mode returns to run leaving stored span untouched.
// - Cancel held at power-on enters low-point trim, blinking with low marker.
// - In trim mode up and down keys trim the loop output drive.
// - Accept at low point stores low trim and moves to high point.
// - Accept at high point stores high trim and continues normal power-up.
// - Timer runs while sensor reads zero; expiry alternates two warning words.
// - Active alarm drives loop output to the fixed fault level.
// - Cancel before alarm shows minutes left; full count means not counting.
// - Holding up for the hold time disables the alarm, flashing bottom bar.
// - Holding up again re-enables alarm, bar off, output follows reading.
// - Accept and up held at power-on erase all stored settings, then boot.
// - Power-up shows identity and version, counts down, then enters run.
// - Reading above a ppm range blanks the right three display digits; a percent range never blanks them.
module kpmc_top
  import kpmc_pkg::*;
#(
  parameter int IDLE_CYC = KPMC_IDLE_CYC,
  parameter int HOLD_CYC = KPMC_HOLD_CYC,
  parameter int TENTH_MIN_CYC = KPMC_TENTH_MIN_CYC,
  parameter int DEBOUNCE_CYC = KPMC_DEBOUNCE_CYC,
  parameter int BLINK_CYC = KPMC_BLINK_CYC,
  parameter int BOOT_STEP_CYC = KPMC_BOOT_STEP_CYC
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Keypad pins.
  input wire logic KEY_UP_B,
  input wire logic KEY_DOWN_B,
  input wire logic KEY_ACCEPT_B,
  input wire logic KEY_CANCEL_B,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Display and loop output.
  output kpmc_disp_s DISP,
  output logic [15:0] LOOP_DRIVE,
  output logic [3:0] MODE
);
  // ----------------------------------------------------------------
  // Key synchronisers, debounce and edges
  // ----------------------------------------------------------------
  logic [3:0] key_raw;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] stable_reg;
  logic [3:0] stable_d_reg;
  logic [31:0] deb_cnt_reg [4];
  logic [3:0] press;
  kpmc_keys_s kp;
  kpmc_keys_s kh;
  assign key_raw = {~KEY_UP_B, ~KEY_DOWN_B, ~KEY_ACCEPT_B, ~KEY_CANCEL_B};
  assign press = stable_reg & ~stable_d_reg;
  assign kp = press;
  assign kh = stable_reg;
  always_ff @(posedge CLK) begin
    sync1_reg <= key_raw;
    sync2_reg <= sync1_reg;
  end
  for (genvar i = 0; i < 4; i++) begin : g_deb
    always_ff @(posedge CLK) begin
      if (!RST_B) begin
        deb_cnt_reg[i] <= '0;
        stable_reg[i] <= 1'b0;
      end else if (sync2_reg[i] == stable_reg[i]) begin
        deb_cnt_reg[i] <= '0;
      end else if (deb_cnt_reg[i] >= 32'(DEBOUNCE_CYC - 1)) begin
        deb_cnt_reg[i] <= '0;
        stable_reg[i] <= sync2_reg[i];
      end else begin
        deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h1;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) stable_d_reg <= '0;
    else stable_d_reg <= stable_reg;
  end
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ph_wr_reg;
  logic [11:0] ph_addr_reg;
  logic [1:0] ctrl_reg;
  logic [15:0] reading_reg;
  logic take;
  assign take = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= '0;
    end else begin
      ph_wr_reg <= take && HWRITE;
      ph_addr_reg <= HADDR[11:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl_reg <= '0;
      reading_reg <= '0;
    end else if (ph_wr_reg) begin
      if (ph_addr_reg == KPMC_OFS_CTRL) ctrl_reg <= HWDATA[1:0];
      if (ph_addr_reg == KPMC_OFS_READING) reading_reg <= HWDATA[15:0];
    end
  end
  // ----------------------------------------------------------------
  // Timers and state
  // ----------------------------------------------------------------
  kpmc_state_e state_reg;
  kpmc_state_e state_next;
  logic [31:0] idle_reg;
  logic [31:0] hold_reg;
  logic [31:0] blink_cnt_reg;
  logic [31:0] boot_cnt_reg;
  logic [31:0] tenth_cnt_reg;
  logic blink_reg;
  logic [7:0] boot_val_reg;
  logic [15:0] alarm_left_reg;
  logic alarm_fired_reg;
  logic alarm_dis_reg;
  logic hold_done_reg;
  logic [15:0] range_reg;
  logic range_pct_reg;
  logic [15:0] edit_reg;
  logic edit_pct_reg;
  logic [15:0] span_reg;
  logic [15:0] trim_lo_reg;
  logic [15:0] trim_hi_reg;
  logic idle_done;
  logic arrow;
  logic sensor_zero;
  logic trace_ok;
  logic [15:0] range_ppm_eq;
  logic over_range;
  logic alarm_out;
  assign idle_done = idle_reg >= 32'(IDLE_CYC - 1);
  assign arrow = kp.up || kp.down;
  assign sensor_zero = ctrl_reg[KPMC_CTRL_SENSOR_ZERO_BIT];
  assign trace_ok = ctrl_reg[KPMC_CTRL_TRACE_BIT];
  assign alarm_out = alarm_fired_reg && !alarm_dis_reg;
  assign range_ppm_eq = range_pct_reg ? KPMC_RANGE_PPM_CEIL : range_reg;
  assign over_range = !range_pct_reg && (reading_reg > range_ppm_eq);
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      idle_reg <= '0;
    end else if (press != 4'h0 || state_reg == KPMC_ST_RUN) begin
      idle_reg <= '0;
    end else if (!idle_done) begin
      idle_reg <= idle_reg + 32'h1;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_reg <= '0;
      blink_reg <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end
  // Long hold of the up key toggles the alarm disable once per hold.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      hold_reg <= '0;
      hold_done_reg <= 1'b0;
      alarm_dis_reg <= 1'b0;
    end else if (!kh.up || state_reg != KPMC_ST_RUN) begin
      hold_reg <= '0;
      hold_done_reg <= 1'b0;
    end else if (!hold_done_reg && hold_reg >= 32'(HOLD_CYC - 1)) begin
      hold_done_reg <= 1'b1;
      alarm_dis_reg <= ~alarm_dis_reg;
    end else if (!hold_done_reg) begin
      hold_reg <= hold_reg + 32'h1;
    end
  end
  // Minutes are kept in tenths so the remaining time reads directly.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tenth_cnt_reg <= '0;
      alarm_left_reg <= KPMC_ALARM_FULL_TENTHS;
      alarm_fired_reg <= 1'b0;
    end else if (!sensor_zero) begin
      tenth_cnt_reg <= '0;
      alarm_left_reg <= KPMC_ALARM_FULL_TENTHS;
      alarm_fired_reg <= 1'b0;
    end else if (alarm_left_reg == 16'h0000) begin
      alarm_fired_reg <= 1'b1;
    end else if (tenth_cnt_reg >= 32'(TENTH_MIN_CYC - 1)) begin
      tenth_cnt_reg <= '0;
      alarm_left_reg <= alarm_left_reg - 16'h0001;
    end else begin
      tenth_cnt_reg <= tenth_cnt_reg + 32'h1;
    end
  end
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      KPMC_ST_POWERUP: begin
        if (sync2_reg != stable_reg) state_next = KPMC_ST_POWERUP;
        else if (kh.accept && kh.up) state_next = KPMC_ST_ERASE;
        else if (kh.cancel) state_next = KPMC_ST_TRIM_LO;
        else state_next = KPMC_ST_BOOT;
      end
      KPMC_ST_ERASE: state_next = KPMC_ST_BOOT;
      KPMC_ST_TRIM_LO: if (kp.accept) state_next = KPMC_ST_TRIM_HI;
      KPMC_ST_TRIM_HI: if (kp.accept) state_next = KPMC_ST_BOOT;
      KPMC_ST_BOOT: if (boot_val_reg == 8'h00 && boot_cnt_reg == 32'h0) state_next = KPMC_ST_RUN;
      KPMC_ST_RUN: begin
        if (kp.accept) state_next = KPMC_ST_ACCEPT1;
        else if (kp.cancel && !alarm_fired_reg) state_next = KPMC_ST_TIMER_SHOW;
      end
      KPMC_ST_ACCEPT1: begin
        if (kp.accept) state_next = KPMC_ST_SPAN;
        else if (arrow) state_next = KPMC_ST_RANGE;
        else if (kp.cancel || idle_done) state_next = KPMC_ST_RUN;
      end
      KPMC_ST_RANGE: if (idle_done) state_next = KPMC_ST_RUN;
      KPMC_ST_SPAN: if (kp.cancel || idle_done) state_next = KPMC_ST_RUN;
      KPMC_ST_TIMER_SHOW: if (press != 4'h0 || idle_done) state_next = KPMC_ST_RUN;
      default: state_next = KPMC_ST_RUN;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) state_reg <= KPMC_ST_POWERUP;
    else state_reg <= state_next;
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      boot_val_reg <= KPMC_BOOT_COUNT;
      boot_cnt_reg <= 32'(BOOT_STEP_CYC - 1);
    end else if (state_reg != KPMC_ST_BOOT) begin
      boot_val_reg <= KPMC_BOOT_COUNT;
      boot_cnt_reg <= 32'(BOOT_STEP_CYC - 1);
    end else if (boot_cnt_reg != 32'h0) begin
      boot_cnt_reg <= boot_cnt_reg - 32'h1;
    end else if (boot_val_reg != 8'h00) begin
      boot_val_reg <= boot_val_reg - 8'h01;
      boot_cnt_reg <= 32'(BOOT_STEP_CYC - 1);
    end
  end
  // ----------------------------------------------------------------
  // Settings and edit value
  // ----------------------------------------------------------------
  logic [15:0] range_floor;
  assign range_floor = trace_ok ? KPMC_RANGE_MIN_PPM : KPMC_RANGE_MIN_PPM + KPMC_STEP;
  always_ff @(posedge CLK) begin
    if (!RST_B || state_reg == KPMC_ST_ERASE) begin
      range_reg <= KPMC_RANGE_RESET;
      range_pct_reg <= 1'b0;
      span_reg <= KPMC_SPAN_RESET;
      trim_lo_reg <= KPMC_TRIM_LO_RESET;
      trim_hi_reg <= KPMC_TRIM_HI_RESET;
      edit_reg <= '0;
      edit_pct_reg <= 1'b0;
    end else begin
      case (state_reg)
        KPMC_ST_RUN: begin
          edit_reg <= range_reg;
          edit_pct_reg <= range_pct_reg;
        end
        KPMC_ST_ACCEPT1, KPMC_ST_RANGE: begin
          if (kp.accept && state_reg == KPMC_ST_ACCEPT1) begin
            edit_reg <= span_reg;
          end else if (kp.up) begin
            if (!edit_pct_reg && edit_reg >= KPMC_RANGE_PPM_CEIL) begin
              edit_pct_reg <= 1'b1;
              edit_reg <= KPMC_RANGE_MIN_PCT_PPM;
            end else if (!(edit_pct_reg && edit_reg >= KPMC_RANGE_MAX_PCT)) begin
              edit_reg <= edit_reg + KPMC_STEP;
            end
          end else if (kp.down) begin
            if (edit_pct_reg && edit_reg <= KPMC_RANGE_MIN_PCT_PPM) begin
              edit_pct_reg <= 1'b0;
              edit_reg <= KPMC_RANGE_PPM_CEIL;
            end else if (edit_pct_reg || edit_reg > range_floor) begin
              edit_reg <= edit_reg - KPMC_STEP;
            end
          end
          if (idle_done) begin
            range_reg <= edit_reg;
            range_pct_reg <= edit_pct_reg;
          end
        end
        KPMC_ST_SPAN: begin
          if (kp.up) edit_reg <= edit_reg + KPMC_STEP;
          else if (kp.down && edit_reg != 16'h0000) edit_reg <= edit_reg - KPMC_STEP;
          if (idle_done && !kp.cancel) span_reg <= edit_reg;
        end
        KPMC_ST_TRIM_LO: begin
          if (kp.up) trim_lo_reg <= trim_lo_reg + KPMC_STEP;
          else if (kp.down) trim_lo_reg <= trim_lo_reg - KPMC_STEP;
        end
        KPMC_ST_TRIM_HI: begin
          if (kp.up) trim_hi_reg <= trim_hi_reg + KPMC_STEP;
          else if (kp.down) trim_hi_reg <= trim_hi_reg - KPMC_STEP;
        end
        default: begin
          edit_reg <= edit_reg;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [15:0] loop_live;
  logic [31:0] scaled;
  logic [15:0] full;
  assign full = range_pct_reg ? KPMC_RANGE_PPM_CEIL : range_reg;
  assign scaled = (32'(reading_reg) * 32'(trim_hi_reg - trim_lo_reg)) / 32'(full == 16'h0 ? 16'h1 : full);
  assign loop_live = over_range ? trim_hi_reg : trim_lo_reg + scaled[15:0];
  always_comb begin
    case (HADDR[11:0])
      KPMC_OFS_CTRL: rd_mux = {30'h0, ctrl_reg};
      KPMC_OFS_STATUS: rd_mux = {24'h0, alarm_dis_reg, alarm_fired_reg, over_range, 1'b0, state_reg};
      KPMC_OFS_RANGE: rd_mux = {15'h0, range_pct_reg, range_reg};
      KPMC_OFS_SPAN: rd_mux = {16'h0, span_reg};
      KPMC_OFS_TRIM: rd_mux = {trim_hi_reg, trim_lo_reg};
      KPMC_OFS_READING: rd_mux = {16'h0, reading_reg};
      KPMC_OFS_ALARM: rd_mux = {16'h0, alarm_left_reg};
      KPMC_OFS_OUTPUT: rd_mux = {16'h0, LOOP_DRIVE};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      if (take && !HWRITE) HRDATA <= rd_mux;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      DISP <= '0;
      LOOP_DRIVE <= KPMC_TRIM_LO_RESET;
      MODE <= KPMC_ST_POWERUP;
    end else begin
      MODE <= state_reg;
      DISP.pct <= 1'b0;
      DISP.blank3 <= 1'b0;
      DISP.alt_warn <= 1'b0;
      DISP.blink <= 1'b0;
      DISP.marker <= KPMC_MK_NONE;
      DISP.value <= reading_reg;
      LOOP_DRIVE <= alarm_out ? KPMC_FAULT_LEVEL : loop_live;
      case (state_reg)
        KPMC_ST_POWERUP, KPMC_ST_ERASE: DISP.value <= KPMC_ID_CODE[15:0];
        KPMC_ST_BOOT: DISP.value <= (boot_val_reg == KPMC_BOOT_COUNT) ? KPMC_VERSION[15:0] : 16'(boot_val_reg);
        KPMC_ST_TRIM_LO: begin
          DISP.blink <= 1'b1;
          DISP.marker <= KPMC_MK_LOW;
          LOOP_DRIVE <= trim_lo_reg;
        end
        KPMC_ST_TRIM_HI: begin
          DISP.blink <= 1'b1;
          DISP.marker <= KPMC_MK_HIGH;
          LOOP_DRIVE <= trim_hi_reg;
        end
        KPMC_ST_ACCEPT1, KPMC_ST_RANGE: begin
          DISP.value <= edit_reg;
          DISP.pct <= edit_pct_reg;
          DISP.blink <= state_reg == KPMC_ST_RANGE;
          DISP.marker <= KPMC_MK_RANGE;
        end
        KPMC_ST_SPAN: begin
          DISP.value <= edit_reg;
          DISP.blink <= 1'b1;
          DISP.marker <= KPMC_MK_SPAN;
        end
        KPMC_ST_TIMER_SHOW: DISP.value <= alarm_left_reg;
        default: begin
          DISP.pct <= range_pct_reg;
          DISP.blank3 <= over_range;
          DISP.alt_warn <= alarm_out;
          if (alarm_dis_reg && blink_reg) DISP.marker <= KPMC_MK_BAR;
        end
      endcase
    end
  end
endmodule

// file: testbench/kpmc_assertions.sv
// Checker that watches the ports of the keypad mode controller.
`timescale 1ns/100ps
module kpmc_assertions
  import kpmc_pkg::*;
#(
  parameter int IDLE_CYC = 20
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Keypad pins.
  input wire logic KEY_UP_B,
  input wire logic KEY_DOWN_B,
  input wire logic KEY_ACCEPT_B,
  input wire logic KEY_CANCEL_B,
  // Bus response.
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Display and loop output.
  input wire kpmc_disp_s DISP,
  input wire logic [15:0] LOOP_DRIVE,
  input wire logic [3:0] MODE
);
  // Key sync and debounce add a few cycles of slack to the idle limit.
  logic [15:0] idle_reg;
  wire keys_idle = KEY_UP_B & KEY_DOWN_B & KEY_ACCEPT_B & KEY_CANCEL_B;
  wire in_edit = (MODE == KPMC_ST_ACCEPT1) || (MODE == KPMC_ST_RANGE) || (MODE == KPMC_ST_SPAN);
  always_ff @(posedge CLK) begin
    idle_reg <= (!RST_B || !keys_idle || !in_edit) ? 16'h0000 : idle_reg + 16'h0001;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_bus; HREADYOUT && !HRESP; endproperty
  a_bus: assert property (p_bus) else $error("Bus not ready or error response.");
  property p_accept1; (MODE == KPMC_ST_ACCEPT1) [*2] |-> DISP.marker == KPMC_MK_RANGE; endproperty
  a_accept1: assert property (p_accept1) else $error("Range marker missing.");
  property p_range; (MODE == KPMC_ST_RANGE) [*2] |-> DISP.blink; endproperty
  a_range: assert property (p_range) else $error("Range value not blinking.");
  property p_range_exit; $fell(MODE == KPMC_ST_RANGE) |-> MODE == KPMC_ST_RUN; endproperty
  a_range_exit: assert property (p_range_exit) else $error("Range mode left to wrong mode.");
  property p_span; (MODE == KPMC_ST_SPAN) [*2] |-> DISP.blink && DISP.marker == KPMC_MK_SPAN; endproperty
  a_span: assert property (p_span) else $error("Span display wrong.");
  property p_span_exit; $fell(MODE == KPMC_ST_SPAN) |-> MODE == KPMC_ST_RUN; endproperty
  a_span_exit: assert property (p_span_exit) else $error("Span mode left to wrong mode.");
  property p_fault; (DISP.alt_warn && DISP.marker != KPMC_MK_BAR) [*2] |-> LOOP_DRIVE == KPMC_FAULT_LEVEL; endproperty
  a_fault: assert property (p_fault) else $error("Loop not at fault level.");
  property p_pct; (MODE == KPMC_ST_RANGE) [*2] ##0 DISP.pct |-> DISP.value inside {[1:25]}; endproperty
  a_pct: assert property (p_pct) else $error("Percent range out of bounds.");
  property p_idle; idle_reg <= IDLE_CYC + 12; endproperty
  a_idle: assert property (p_idle) else $error("Edit mode did not time out.");
  c_span: cover property (MODE == KPMC_ST_SPAN);
  c_warn: cover property (DISP.alt_warn);
  c_pct: cover property (DISP.pct);
endmodule
bind kpmc_top kpmc_assertions #(.IDLE_CYC(IDLE_CYC)) kpmc_assertions_inst (.CLK(CLK), .RST_B(RST_B),
  .KEY_UP_B(KEY_UP_B), .KEY_DOWN_B(KEY_DOWN_B), .KEY_ACCEPT_B(KEY_ACCEPT_B), .KEY_CANCEL_B(KEY_CANCEL_B),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DISP(DISP), .LOOP_DRIVE(LOOP_DRIVE), .MODE(MODE));

// file: testbench/kpmc_keys.sv
// Operator keypad model that presses and holds keys on the active-low pins.
`timescale 1ns/100ps
module kpmc_keys
  import kpmc_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Key pins, low while pressed.
  output logic key_up_b,
  output logic key_dn_b,
  output logic key_ac_b,
  output logic key_cn_b
);
  kpmc_keys_s keys_reg = 4'h0;
  // A released key is pulled up, so an idle pin reads high.
  assign key_up_b = !keys_reg.up;
  assign key_dn_b = !keys_reg.down;
  assign key_ac_b = !keys_reg.accept;
  assign key_cn_b = !keys_reg.cancel;
  // Each press ends with a release long enough to count as a new press.
  task automatic hold(input kpmc_keys_s k, input int n);
    @(posedge clk);
    keys_reg <= k;
    repeat (n) @(posedge clk);
    keys_reg <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the keypad mode controller.
`timescale 1ns/100ps
module tb
  import kpmc_pkg::*;
;
  localparam int HOLD = 30;
  localparam kpmc_keys_s K_UP = 4'h8;
  localparam kpmc_keys_s K_DN = 4'h4;
  localparam kpmc_keys_s K_AC = 4'h2;
  localparam kpmc_keys_s K_CN = 4'h1;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, bar;
  kpmc_disp_s disp;
  logic [15:0] loop_drive;
  logic [3:0] mode;
  wire key_up_b, key_dn_b, key_ac_b, key_cn_b;
  int error_cnt = 0;
  int n_tests = 0;
  int i;
  always #12.5 clk = ~clk;
  kpmc_top #(.IDLE_CYC(24), .HOLD_CYC(HOLD), .TENTH_MIN_CYC(5), .DEBOUNCE_CYC(1), .BLINK_CYC(4),
    .BOOT_STEP_CYC(2)) kpmc_top_inst (.CLK(clk), .RST_B(rst_b), .KEY_UP_B(key_up_b), .KEY_DOWN_B(key_dn_b),
    .KEY_ACCEPT_B(key_ac_b), .KEY_CANCEL_B(key_cn_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .DISP(disp), .LOOP_DRIVE(loop_drive), .MODE(mode));
  kpmc_keys kpmc_keys_inst (.clk(clk), .key_up_b(key_up_b), .key_dn_b(key_dn_b), .key_ac_b(key_ac_b),
    .key_cn_b(key_cn_b));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic stuck();
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    end_of_test();
  endtask
  task automatic wait_mode(input kpmc_state_e m, input int lim);
    for (i = 0; i < lim && mode !== m; i++) @(posedge clk);
    if (mode !== m) stuck();
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    repeat (2) begin
      for (i = 0; i < 50; i++) begin
        @(posedge clk);
        if (hreadyout === 1'b1) break;
      end
      if (hreadyout !== 1'b1) stuck();
      q = hrdata;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
    end
    @(posedge clk);
  endtask
  task automatic scan_bar();
    bar = 1'b0;
    repeat (10) begin
      @(posedge clk);
      bar = bar | (disp.marker == KPMC_MK_BAR);
    end
  endtask
  task automatic t_reset();
    chk(32'(loop_drive), 32'h00000333);
    chk(32'(mode), 32'(KPMC_ST_POWERUP));
    rst_b <= 1'b1;
    wait_mode(KPMC_ST_RUN, 3000);
    chk(32'(mode), 32'(KPMC_ST_RUN));
    bus(KPMC_OFS_SPAN, 1'b0, 32'h0);
    chk(q, 32'h000003E8);
    bus(KPMC_OFS_TRIM, 1'b0, 32'h0);
    chk(q, 32'h0FFF0333);
    bus(KPMC_OFS_ALARM, 1'b0, 32'h0);
    chk(q, 32'h0000012C);
    bus(12'h040, 1'b0, 32'h0);
    chk(q, 32'h00000000);
    $display("Reset and boot test done");
  endtask
  task automatic t_range();
    kpmc_keys_inst.hold(K_AC, 8);
    chk(32'(mode), 32'(KPMC_ST_ACCEPT1));
    chk(32'(disp.marker), 32'(KPMC_MK_RANGE));
    repeat (3) kpmc_keys_inst.hold(K_UP, 8);
    kpmc_keys_inst.hold(K_DN, 8);
    chk(32'(disp.value), 32'h00000066);
    wait_mode(KPMC_ST_RUN, 200);
    bus(KPMC_OFS_RANGE, 1'b0, 32'h0);
    chk(32'(q[15:0]), 32'h00000066);
    kpmc_keys_inst.hold(K_AC, 8);
    kpmc_keys_inst.hold(K_UP, 8);
    repeat (95) kpmc_keys_inst.hold(K_DN, 8);
    chk(32'(disp.value), 32'h0000000B);
    bus(KPMC_OFS_CTRL, 1'b1, 32'h00000001);
    kpmc_keys_inst.hold(K_DN, 8);
    chk(32'(disp.value), 32'h0000000A);
    repeat (991) kpmc_keys_inst.hold(K_UP, 8);
    chk(32'({disp.pct, disp.value}), 32'h00010001);
    wait_mode(KPMC_ST_RUN, 200);
    bus(KPMC_OFS_RANGE, 1'b0, 32'h0);
    chk(32'(q[15:0]), 32'h00000001);
    $display("Range test done");
  endtask
  task automatic t_span();
    repeat (2) kpmc_keys_inst.hold(K_AC, 8);
    chk(32'(mode), 32'(KPMC_ST_SPAN));
    kpmc_keys_inst.hold(K_UP, 8);
    chk(32'(disp.value), 32'h000003E9);
    kpmc_keys_inst.hold(K_CN, 8);
    chk(32'(mode), 32'(KPMC_ST_RUN));
    bus(KPMC_OFS_SPAN, 1'b0, 32'h0);
    chk(q, 32'h000003E8);
    repeat (2) kpmc_keys_inst.hold(K_AC, 8);
    repeat (2) kpmc_keys_inst.hold(K_UP, 8);
    wait_mode(KPMC_ST_RUN, 200);
    chk(32'(disp.marker), 32'(KPMC_MK_NONE));
    bus(KPMC_OFS_SPAN, 1'b0, 32'h0);
    chk(q, 32'h000003EA);
    $display("Span test done");
  endtask
  task automatic t_alarm();
    bus(KPMC_OFS_CTRL, 1'b1, 32'h00000003);
    kpmc_keys_inst.hold(K_CN, 8);
    chk(32'(mode), 32'(KPMC_ST_TIMER_SHOW));
    bus(KPMC_OFS_ALARM, 1'b0, 32'h0);
    chk(32'(q < 32'h0000012C), 32'h00000001);
    for (i = 0; i < 3000 && disp.alt_warn !== 1'b1; i++) @(posedge clk);
    chk(32'(disp.alt_warn), 32'h00000001);
    chk(32'(loop_drive), 32'(KPMC_FAULT_LEVEL));
    kpmc_keys_inst.hold(K_UP, HOLD + 10);
    scan_bar();
    chk(32'(bar), 32'h00000001);
    chk(32'(loop_drive !== KPMC_FAULT_LEVEL), 32'h00000001);
    bus(KPMC_OFS_CTRL, 1'b1, 32'h00000001);
    kpmc_keys_inst.hold(K_UP, HOLD + 10);
    scan_bar();
    chk(32'(bar), 32'h00000000);
    $display("Sensor alarm test done");
  endtask
  task automatic t_trim();
    rst_b <= 1'b0;
    fork kpmc_keys_inst.hold(K_CN, 8); join_none
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    wait_mode(KPMC_ST_TRIM_LO, 20);
    kpmc_keys_inst.hold(K_UP, 8);
    chk(32'(loop_drive), 32'h00000334);
    kpmc_keys_inst.hold(K_AC, 8);
    chk(32'(mode), 32'(KPMC_ST_TRIM_HI));
    kpmc_keys_inst.hold(K_AC, 8);
    wait_mode(KPMC_ST_RUN, 3000);
    bus(KPMC_OFS_TRIM, 1'b0, 32'h0);
    chk(q, 32'h0FFF0334);
    $display("Trim test done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    t_reset();
    t_range();
    t_span();
    t_alarm();
    t_trim();
    end_of_test();
  end
endmodule
